// file: dv/dafs_far_side.sv
// far side model: contacts, host link and remote operator
`timescale 1ns/1ns
module dafs_far_side (
  input wire logic aclk,
  input wire logic aresetn,
  input dafs_pkg::dafs_sense_t want,
  output dafs_pkg::dafs_sense_t sense
);
  // contacts follow the bench one edge later
  always_ff @(posedge aclk) begin
    sense <= want;
    // operator link comes up right after power-up
    sense.op_link_ok <= aresetn;
    // no operator transmission errors
    sense.op_tx_error <= 1'b0;
  end
endmodule : dafs_far_side

// file: dv/dafs_supervisor_props.sv
// port checker for the alarm and fault supervisor
`timescale 1ns/1ns
module dafs_supervisor_props #(
  parameter int unsigned TICK_CYCLES = 10
) (
  input wire logic aclk,
  input wire logic aresetn,
  input dafs_pkg::dafs_axi_req_t axi_req,
  input dafs_pkg::dafs_axi_rsp_t axi_rsp,
  input dafs_pkg::dafs_sense_t sense,
  input dafs_pkg::dafs_ind_t ind
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // fault held for three cycles
  sequence fault_held;
    ind.fault_active [*3];
  endsequence
  a_fault_coasts: assert property (ind.fault_active |-> !ind.motor_enable)
    else $error("motor enabled during fault");
  a_fault_steady: assert property (fault_held |-> ind.disp_on)
    else $error("fault display not steady");
  a_relay_from_fault: assert property (ind.fault_relay_terminals |-> ind.fault_relay)
    else $error("relay terminals without fault");
  a_block_cuts: assert property (sense.output_block_in |-> ##[1:2] !ind.motor_enable)
    else $error("output not cut by block input");
  a_prom_trips: assert property (sense.prom_fail |-> ##[1:2] ind.fault_relay)
    else $error("memory failure did not trip");
  a_term_trips: assert property (|sense.ext_fault_in |-> ##[1:2] ind.fault_active)
    else $error("terminal fault not declared");
  a_opt_trips: assert property (sense.serial_opt_fault |-> ##[1:2] ind.fault_active)
    else $error("option fault not declared");
  a_extoh_alarms: assert property (sense.ext_overheat_in |-> ##[1:2] ind.alarm_active)
    else $error("overheat input gave no alarm");
endmodule : dafs_supervisor_props

bind dafs_supervisor dafs_supervisor_props #(.TICK_CYCLES(TICK_CYCLES)) dafs_supervisor_props_i (
  .aclk(aclk), .aresetn(aresetn), .axi_req(axi_req), .axi_rsp(axi_rsp), .sense(sense),
  .ind(ind));

// file: dv/drive_alarm_fault_supervisor_bench.sv
// self-checking bench for the alarm and fault supervisor
`timescale 1ns/1ns
module drive_alarm_fault_supervisor_bench;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  dafs_pkg::dafs_axi_req_t req = '0;
  dafs_pkg::dafs_axi_rsp_t rsp;
  dafs_pkg::dafs_sense_t want = '0;
  dafs_pkg::dafs_sense_t sense;
  dafs_pkg::dafs_ind_t ind;
  int miscompares = 0;
  int samples_checked = 0;
  int cycles = 0;
  logic [31:0] rd;
  logic [1:0] rr;
  always #50 aclk = ~aclk;
  dafs_supervisor #(.TICK_CYCLES(10)) dafs_supervisor_i (.aclk(aclk), .aresetn(aresetn),
    .axi_req(req), .axi_rsp(rsp), .sense(sense), .ind(ind));
  dafs_far_side dafs_far_side_i (.aclk(aclk), .aresetn(aresetn), .want(want), .sense(sense));
  // verdict and end of run
  task complete_run;
    $display("checked %0d mismatched %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : complete_run
  // hang guard
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      complete_run();
    end
  end
  // compare one value
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task wt(input int n);
    repeat (n) @(posedge aclk);
  endtask : wt
  // axi4-lite write, address and data released as each is taken
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic ga, gw;
    ga = 1'b0;
    gw = 1'b0;
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    while (!(ga && gw)) begin
      @(posedge aclk);
      if (rsp.awready && !ga) begin
        ga = 1'b1;
        req.awvalid <= 1'b0;
      end
      if (rsp.wready && !gw) begin
        gw = 1'b1;
        req.wvalid <= 1'b0;
      end
    end
    req.bready <= 1'b1;
    do @(posedge aclk); while (rsp.bvalid !== 1'b1);
    req.bready <= 1'b0;
    @(posedge aclk);
  endtask : wr
  // axi4-lite read
  task rdr(input logic [7:0] a);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (rsp.arready) req.arvalid <= 1'b0;
    end while (rsp.rvalid !== 1'b1);
    rd = rsp.rdata;
    rr = rsp.rresp;
    req.rready <= 1'b0;
    @(posedge aclk);
  endtask : rdr
  initial begin
    wt(6);
    aresetn <= 1'b1;
    wt(3);
    // quiet after reset, unmapped read refused
    rdr(dafs_pkg::ADDR_STAT);
    chk("stat", 0, rd);
    rdr(8'h2c);
    chk("unmapped resp", dafs_pkg::RESP_SLVERR, rr);
    $display("test reset done");
    // block input cuts a running output
    want.run_fwd <= 1'b1;
    wt(4);
    chk("run", 1, ind.motor_enable);
    want.output_block_in <= 1'b1;
    wt(4);
    chk("block motor", 0, ind.motor_enable);
    rdr(dafs_pkg::ADDR_STAT);
    chk("block alarm", 1, rd[0]);
    want.output_block_in <= 1'b0;
    wt(4);
    chk("unblock", 1, ind.motor_enable);
    $display("test block done");
    // terminal 4 trips, relay function, history, repeat
    want.ext_fault_in <= 5'h04;
    wt(4);
    want.ext_fault_in <= 5'h00;
    chk("relay terminals", 1, ind.fault_relay_terminals);
    chk("fault code", 8'h64, ind.disp_code);
    rdr(dafs_pkg::ADDR_STAT);
    chk("terminal", 4, rd[31:29]);
    wr(dafs_pkg::ADDR_CFG, 32'h1);
    wt(3);
    chk("relay fn", 0, ind.fault_relay_terminals);
    wr(dafs_pkg::ADDR_CMD, 32'h1);
    want.ext_fault_in <= 5'h04;
    wt(4);
    want.ext_fault_in <= 5'h00;
    rdr(dafs_pkg::ADDR_HIST);
    chk("history", 11'h164, rd[10:0]);
    wr(dafs_pkg::ADDR_CMD, 32'h1);
    wt(3);
    chk("cleared", 0, ind.fault_active);
    $display("test fault done");
    // alarm keeps running and is not logged
    want.ext_overheat_in <= 1'b1;
    wt(4);
    chk("overheat", 1, ind.alarm_active);
    chk("alarm run", 1, ind.motor_enable);
    rdr(dafs_pkg::ADDR_HIST);
    chk("no log", 1, rd[10:8]);
    $display("test alarm done");
    // memory failure and option fault trip while the alarm stands
    want.prom_fail <= 1'b1;
    want.serial_opt_fault <= 1'b1;
    wt(4);
    want.prom_fail <= 1'b0;
    want.serial_opt_fault <= 1'b0;
    want.ext_overheat_in <= 1'b0;
    chk("trip relay", 1, ind.fault_relay);
    chk("trip motor", 0, ind.motor_enable);
    chk("trip code", 8'h43, ind.disp_code);
    chk("trip steady", 1, ind.disp_on);
    rdr(dafs_pkg::ADDR_STAT);
    chk("trip causes", 9'h028, rd[20:12]);
    rdr(dafs_pkg::ADDR_HIST);
    chk("history count", 11'h264, rd[10:0]);
    wr(dafs_pkg::ADDR_CMD, 32'h1);
    wt(3);
    chk("trip cleared", 0, ind.fault_active);
    $display("test trip done");
    // both run inputs: 500 ticks of 10 cycles
    want.run_rev <= 1'b1;
    wt(4900);
    chk("conflict early", 1, ind.motor_enable);
    wt(300);
    chk("conflict", 0, ind.motor_enable);
    want.run_rev <= 1'b0;
    wt(5);
    chk("conflict gone", 1, ind.motor_enable);
    $display("test conflict done");
    // prohibit low above high while programming
    wr(dafs_pkg::ADDR_CFG, 32'h100);
    wr(dafs_pkg::ADDR_FREQ, 32'h0001_0002);
    wt(4);
    rdr(dafs_pkg::ADDR_STAT);
    chk("consistency", 1, rd[27]);
    $display("test param done");
    complete_run();
  end
endmodule : drive_alarm_fault_supervisor_bench

// file: shared/dafs_pkg.sv
// package of constants and carriers for the drive alarm and fault supervisor
package dafs_pkg;
  // clock and common tick
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned TICK_US = 1000;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;
  // supervision times in their own units
  localparam int unsigned CE_TIMEOUT_S = 2;
  localparam int unsigned RUN_CONFLICT_MS = 500;
  localparam int unsigned OPL_START_S = 5;
  localparam int unsigned OPL_LOSS_S = 2;
  localparam int unsigned BLINK_HALF_MS = 250;
  localparam int unsigned WRFAIL_SHOW_MS = 1000;
  // the same times counted in ticks
  localparam logic [12:0] CE_TICKS = 13'(CE_TIMEOUT_S * 1_000_000 / TICK_US);
  localparam logic [12:0] RC_TICKS = 13'(RUN_CONFLICT_MS * 1000 / TICK_US);
  localparam logic [12:0] OPS_TICKS = 13'(OPL_START_S * 1_000_000 / TICK_US);
  localparam logic [12:0] OPL_TICKS = 13'(OPL_LOSS_S * 1_000_000 / TICK_US);
  localparam logic [12:0] BLINK_TICKS = 13'(BLINK_HALF_MS * 1000 / TICK_US);
  localparam logic [12:0] WRF_TICKS = 13'(WRFAIL_SHOW_MS * 1000 / TICK_US);
  // monitor thresholds and parameter codes
  localparam logic [7:0] HEAT_ALARM_C = 8'h5a;
  localparam logic [3:0] RELAY_FN_FAULT = 4'h0;
  localparam logic [3:0] AIM_MASTER = 4'h2;
  localparam logic [4:0] MFI_MASTER_SEL = 5'h09;
  localparam logic [4:0] MFI_SEL_MAX = 5'h19;
  localparam logic [7:0] CAP_MAX = 8'h0f;
  // register byte addresses
  localparam logic [7:0] ADDR_CFG = 8'h00;
  localparam logic [7:0] ADDR_FREQ = 8'h04;
  localparam logic [7:0] ADDR_LIM = 8'h08;
  localparam logic [7:0] ADDR_MFI = 8'h0c;
  localparam logic [7:0] ADDR_VFF = 8'h10;
  localparam logic [7:0] ADDR_VFV = 8'h14;
  localparam logic [7:0] ADDR_MISC = 8'h18;
  localparam logic [7:0] ADDR_CMD = 8'h1c;
  localparam logic [7:0] ADDR_STAT = 8'h20;
  localparam logic [7:0] ADDR_HIST = 8'h24;
  localparam logic [7:0] ADDR_DISP = 8'h28;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // field positions
  localparam int CFG_SEQ_SERIAL = 4;
  localparam int CFG_HEAT_CONT = 5;
  localparam int CFG_OT_CONT = 6;
  localparam int CFG_CE_FAULT = 7;
  localparam int CFG_PROG = 8;
  localparam int CMD_FAULT_RESET = 0;
  // alarm bit indices
  localparam int A_BLOCK = 0, A_CALL = 1, A_CE = 2, A_RC = 3, A_HEAT = 4;
  localparam int A_EXTOH = 5, A_OT = 6, A_BUS_HI = 7, A_BUS_LO = 8, NA = 9;
  // fault bit indices
  localparam int F_CE = 0, F_OPS = 1, F_OPL = 2, F_PROM = 3, F_ADC = 4;
  localparam int F_SOPT = 5, F_TERM = 6, F_HEAT = 7, F_OT = 8, NF = 9;
  // faults written to the history; control function errors are kept out
  localparam logic [8:0] LOG_MASK = 9'h1e1;
  // parameter error bit indices
  localparam int P_CAP = 0, P_MFI = 1, P_VF = 2, P_CONS = 3;
  // display codes
  localparam logic [7:0] CODE_NONE = 8'h00;
  localparam logic [7:0] CODE_ALARM_BASE = 8'h10;
  localparam logic [7:0] CODE_FAULT_BASE = 8'h40;
  localparam logic [7:0] CODE_TERM_BASE = 8'h60;
  localparam logic [7:0] CODE_PERR_BASE = 8'h30;
  localparam logic [7:0] CODE_WRFAIL = 8'h3f;
  localparam int HIST_DEPTH = 4;

  // operator link supervision states
  typedef enum logic [2:0] {
    OPL_WAIT = 3'b001,
    OPL_UP = 3'b010,
    OPL_FAIL = 3'b100
  } dafs_opl_t;

  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } dafs_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } dafs_axi_rsp_t;

  typedef struct packed {
    logic run_fwd;
    logic run_rev;
    logic output_block_in;
    logic host_link_up;
    logic ctrl_rx_error;
    logic op_link_ok;
    logic op_tx_error;
    logic [4:0] ext_fault_in;
    logic serial_opt_fault;
    logic [7:0] heatsink_temp;
    logic ext_overheat_in;
    logic [15:0] output_torque;
    logic bus_ov_mon;
    logic bus_uv_mon;
    logic drive_running;
    logic prom_fail;
    logic adc_fail;
    logic nv_write_fail;
  } dafs_sense_t;

  typedef struct packed {
    logic motor_enable;
    logic fault_relay;
    logic fault_relay_terminals;
    logic [7:0] disp_code;
    logic disp_on;
    logic alarm_active;
    logic fault_active;
  } dafs_ind_t;

  typedef struct packed {
    logic [HIST_DEPTH-1:0][7:0] mem;
    logic [7:0] rdata;
  } dafs_mem_state_t;

  typedef struct packed {
    logic aw_have;
    logic [7:0] awaddr;
    logic w_have;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    dafs_axi_rsp_t rsp;
    logic [31:0] cfg, freq, lim, mfi, vff, vfv, misc;
    logic [13:0] tick_cnt;
    logic [12:0] ce_cnt, rc_cnt, opl_cnt, blink_cnt, wf_cnt;
    logic blink_ph;
    logic wf_show;
    dafs_opl_t opl;
    logic powered;
    logic prog_prev;
    logic [3:0] perr;
    logic [NA-1:0] alarms;
    logic [NF-1:0] faults, logged;
    logic [2:0] term_num;
    logic [2:0] hist_cnt;
    logic [7:0] hist_last;
    dafs_ind_t ind;
  } dafs_state_t;
endpackage : dafs_pkg

// file: src/dafs_hist_mem.sv
// fault history storage, four codes, registered read port
`timescale 1ns/1ns
module dafs_hist_mem (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic we,
  input wire logic [1:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [1:0] raddr,
  output logic [7:0] rdata
);
  dafs_pkg::dafs_mem_state_t s_r; // stored codes and read register
  dafs_pkg::dafs_mem_state_t s_nxt; // next value

  // write port and registered read
  always_comb begin
    s_nxt = s_r;
    if (we) begin
      s_nxt.mem[waddr] = wdata;
    end
    s_nxt.rdata = s_r.mem[raddr];
  end

  // state register, synchronous reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rdata = s_r.rdata;
endmodule : dafs_hist_mem

// file: src/dafs_supervisor.sv
// drive alarm and fault supervisor with axi4-lite registers
`timescale 1ns/1ns
module dafs_supervisor #(
  parameter int unsigned TICK_CYCLES = dafs_pkg::TICK_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input dafs_pkg::dafs_axi_req_t axi_req,
  output dafs_pkg::dafs_axi_rsp_t axi_rsp,
  input dafs_pkg::dafs_sense_t sense,
  output dafs_pkg::dafs_ind_t ind
);
  localparam logic [13:0] TICK_LAST = 14'(TICK_CYCLES - 1);

  dafs_pkg::dafs_state_t s_r; // whole block state
  dafs_pkg::dafs_state_t s_nxt; // next state
  logic tick; // common one-ms enable
  logic clr_faults; // software fault reset
  logic eval; // parameter check moment
  logic prog; // programming mode
  logic [dafs_pkg::NA-1:0] aset; // live alarm conditions
  logic [dafs_pkg::NF-1:0] fset; // fault causes this cycle
  logic [3:0] perr_now; // parameter checks
  logic [4:0] pick; // next fault to log
  logic [4:0] fsel; // fault to display
  logic [4:0] asel; // alarm to display
  logic [4:0] psel; // parameter error to display
  logic [7:0] log_code; // code of picked fault
  logic [2:0] term_hit; // lowest tripping terminal
  logic mem_we; // history write
  logic [7:0] mem_rdata; // history read data

  // timer step: counts ticks while cond, clears when it drops
  function automatic logic [12:0] tmr(input logic [12:0] cnt, input logic cond,
                                      input logic tk, input logic [12:0] lim);
    if (!cond) begin
      tmr = 13'h0000;
    end else if (tk && cnt < lim) begin
      tmr = cnt + 13'h0001;
    end else begin
      tmr = cnt;
    end
  endfunction : tmr

  // lowest set bit: {found, index}
  function automatic logic [4:0] lowest(input logic [8:0] v);
    lowest = 5'h00;
    for (int i = 8; i >= 0; i--) begin
      if (v[i]) begin
        lowest = {1'b1, 4'(i)};
      end
    end
  endfunction : lowest

  // byte-lane merge of a register write
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] strb);
    merge = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        merge[8*b +: 8] = d[8*b +: 8];
      end
    end
  endfunction : merge

  // multi-function selection field k
  function automatic logic [4:0] mfsel(input logic [31:0] m, input int k);
    mfsel = m[5*k +: 5];
  endfunction : mfsel

  // display code of a fault index
  function automatic logic [7:0] fcode(input logic [3:0] idx, input logic [2:0] tn);
    if (idx == 4'(dafs_pkg::F_TERM)) begin
      fcode = dafs_pkg::CODE_TERM_BASE + {5'h00, tn};
    end else begin
      fcode = dafs_pkg::CODE_FAULT_BASE + {4'h0, idx};
    end
  endfunction : fcode

  dafs_hist_mem u_hist (
    .aclk(aclk),
    .aresetn(aresetn),
    .we(mem_we),
    .waddr(s_r.hist_cnt[1:0]),
    .wdata(log_code),
    .raddr(s_r.cfg[10:9]),
    .rdata(mem_rdata)
  );

  // next-state logic
  always_comb begin
    s_nxt = s_r;
    clr_faults = 1'b0;
    mem_we = 1'b0;
    prog = s_r.cfg[dafs_pkg::CFG_PROG];
    // common tick divider
    tick = (s_r.tick_cnt == TICK_LAST);
    s_nxt.tick_cnt = tick ? 14'h0000 : s_r.tick_cnt + 14'h0001;

    // axi write address and data, taken in either order
    if (s_r.rsp.awready && axi_req.awvalid) begin
      s_nxt.aw_have = 1'b1;
      s_nxt.awaddr = axi_req.awaddr;
    end
    if (s_r.rsp.wready && axi_req.wvalid) begin
      s_nxt.w_have = 1'b1;
      s_nxt.wdata = axi_req.wdata;
      s_nxt.wstrb = axi_req.wstrb;
    end
    if (s_r.rsp.bvalid && axi_req.bready) begin
      s_nxt.rsp.bvalid = 1'b0;
    end
    // perform write once both halves held
    if (s_r.aw_have && s_r.w_have && !s_r.rsp.bvalid) begin
      s_nxt.aw_have = 1'b0;
      s_nxt.w_have = 1'b0;
      s_nxt.rsp.bvalid = 1'b1;
      s_nxt.rsp.bresp = dafs_pkg::RESP_OKAY;
      unique case (s_r.awaddr)
        dafs_pkg::ADDR_CFG: s_nxt.cfg = merge(s_r.cfg, s_r.wdata, s_r.wstrb);
        dafs_pkg::ADDR_FREQ: s_nxt.freq = merge(s_r.freq, s_r.wdata, s_r.wstrb);
        dafs_pkg::ADDR_LIM: s_nxt.lim = merge(s_r.lim, s_r.wdata, s_r.wstrb);
        dafs_pkg::ADDR_MFI: s_nxt.mfi = merge(s_r.mfi, s_r.wdata, s_r.wstrb);
        dafs_pkg::ADDR_VFF: s_nxt.vff = merge(s_r.vff, s_r.wdata, s_r.wstrb);
        dafs_pkg::ADDR_VFV: s_nxt.vfv = merge(s_r.vfv, s_r.wdata, s_r.wstrb);
        dafs_pkg::ADDR_MISC: s_nxt.misc = merge(s_r.misc, s_r.wdata, s_r.wstrb);
        dafs_pkg::ADDR_CMD: begin
          // fault reset strobe
          clr_faults = s_r.wstrb[0] & s_r.wdata[dafs_pkg::CMD_FAULT_RESET];
        end
        default: s_nxt.rsp.bresp = dafs_pkg::RESP_SLVERR; // unmapped
      endcase
    end
    s_nxt.rsp.awready = !s_nxt.aw_have && !s_nxt.rsp.bvalid;
    s_nxt.rsp.wready = !s_nxt.w_have && !s_nxt.rsp.bvalid;

    // axi read
    if (s_r.rsp.rvalid && axi_req.rready) begin
      s_nxt.rsp.rvalid = 1'b0;
    end
    if (s_r.rsp.arready && axi_req.arvalid) begin
      s_nxt.rsp.rvalid = 1'b1;
      s_nxt.rsp.rresp = dafs_pkg::RESP_OKAY;
      unique case (axi_req.araddr)
        dafs_pkg::ADDR_CFG: s_nxt.rsp.rdata = s_r.cfg;
        dafs_pkg::ADDR_FREQ: s_nxt.rsp.rdata = s_r.freq;
        dafs_pkg::ADDR_LIM: s_nxt.rsp.rdata = s_r.lim;
        dafs_pkg::ADDR_MFI: s_nxt.rsp.rdata = s_r.mfi;
        dafs_pkg::ADDR_VFF: s_nxt.rsp.rdata = s_r.vff;
        dafs_pkg::ADDR_VFV: s_nxt.rsp.rdata = s_r.vfv;
        dafs_pkg::ADDR_MISC: s_nxt.rsp.rdata = s_r.misc;
        dafs_pkg::ADDR_CMD: s_nxt.rsp.rdata = dafs_pkg::REG_RESET; // write only
        dafs_pkg::ADDR_STAT: begin
          s_nxt.rsp.rdata = {s_r.term_num, s_r.wf_show, s_r.perr, 3'h0, s_r.faults,
                             3'h0, s_r.alarms};
        end
        dafs_pkg::ADDR_HIST: s_nxt.rsp.rdata = {21'h000000, s_r.hist_cnt, mem_rdata};
        dafs_pkg::ADDR_DISP: begin
          s_nxt.rsp.rdata = {23'h000000, s_r.ind.disp_on, s_r.ind.disp_code};
        end
        default: begin
          // unmapped read
          s_nxt.rsp.rdata = dafs_pkg::REG_RESET;
          s_nxt.rsp.rresp = dafs_pkg::RESP_SLVERR;
        end
      endcase
    end
    s_nxt.rsp.arready = !s_nxt.rsp.rvalid;

    // supervision timers
    s_nxt.ce_cnt = tmr(s_r.ce_cnt, sense.ctrl_rx_error, tick, dafs_pkg::CE_TICKS);
    s_nxt.rc_cnt = tmr(s_r.rc_cnt, sense.run_fwd & sense.run_rev, tick,
                       dafs_pkg::RC_TICKS);

    // live alarm conditions
    aset = '0;
    aset[dafs_pkg::A_BLOCK] = sense.output_block_in;
    aset[dafs_pkg::A_CALL] = s_r.cfg[dafs_pkg::CFG_SEQ_SERIAL] & ~sense.host_link_up;
    aset[dafs_pkg::A_CE] = (s_r.ce_cnt == dafs_pkg::CE_TICKS) &
                           ~s_r.cfg[dafs_pkg::CFG_CE_FAULT];
    aset[dafs_pkg::A_RC] = (s_r.rc_cnt == dafs_pkg::RC_TICKS);
    aset[dafs_pkg::A_HEAT] = (sense.heatsink_temp > dafs_pkg::HEAT_ALARM_C) &
                             s_r.cfg[dafs_pkg::CFG_HEAT_CONT];
    aset[dafs_pkg::A_EXTOH] = sense.ext_overheat_in;
    aset[dafs_pkg::A_OT] = (sense.output_torque > s_r.misc[31:16]) &
                           s_r.cfg[dafs_pkg::CFG_OT_CONT];
    aset[dafs_pkg::A_BUS_HI] = sense.bus_ov_mon & ~sense.drive_running;
    aset[dafs_pkg::A_BUS_LO] = sense.bus_uv_mon & ~sense.drive_running;
    s_nxt.alarms = aset;

    // operator link supervision
    s_nxt.opl_cnt = s_r.opl_cnt;
    unique case (s_r.opl)
      dafs_pkg::OPL_WAIT: begin
        s_nxt.opl_cnt = tmr(s_r.opl_cnt, 1'b1, tick, dafs_pkg::OPS_TICKS);
        if (sense.op_link_ok) begin
          s_nxt.opl = dafs_pkg::OPL_UP;
          s_nxt.opl_cnt = 13'h0000;
        end else if (s_r.opl_cnt == dafs_pkg::OPS_TICKS) begin
          s_nxt.opl = dafs_pkg::OPL_FAIL;
        end
      end
      dafs_pkg::OPL_UP: begin
        s_nxt.opl_cnt = tmr(s_r.opl_cnt, sense.op_tx_error, tick, dafs_pkg::OPL_TICKS);
      end
      dafs_pkg::OPL_FAIL: begin
        if (sense.op_link_ok) begin
          s_nxt.opl = dafs_pkg::OPL_UP;
          s_nxt.opl_cnt = 13'h0000;
        end
      end
      default: begin
        s_nxt.opl = dafs_pkg::OPL_WAIT;
        s_nxt.opl_cnt = 13'h0000;
      end
    endcase

    // fault causes
    term_hit = 3'h0;
    for (int t = 4; t >= 0; t--) begin
      if (sense.ext_fault_in[t]) begin
        term_hit = 3'(t + 2);
      end
    end
    fset = '0;
    fset[dafs_pkg::F_CE] = (s_r.ce_cnt == dafs_pkg::CE_TICKS) &
                           s_r.cfg[dafs_pkg::CFG_CE_FAULT];
    fset[dafs_pkg::F_OPS] = (s_r.opl == dafs_pkg::OPL_FAIL);
    fset[dafs_pkg::F_OPL] = (s_r.opl == dafs_pkg::OPL_UP) &
                            (s_r.opl_cnt == dafs_pkg::OPL_TICKS);
    fset[dafs_pkg::F_PROM] = sense.prom_fail;
    fset[dafs_pkg::F_ADC] = sense.adc_fail;
    fset[dafs_pkg::F_SOPT] = sense.serial_opt_fault;
    fset[dafs_pkg::F_TERM] = |sense.ext_fault_in;
    fset[dafs_pkg::F_HEAT] = (sense.heatsink_temp > dafs_pkg::HEAT_ALARM_C) &
                             ~s_r.cfg[dafs_pkg::CFG_HEAT_CONT];
    fset[dafs_pkg::F_OT] = (sense.output_torque > s_r.misc[31:16]) &
                           ~s_r.cfg[dafs_pkg::CFG_OT_CONT];
    // latch faults; a new cause wins over a reset
    s_nxt.faults = (s_r.faults & {dafs_pkg::NF{~clr_faults}}) | fset;
    if (fset[dafs_pkg::F_TERM] && !s_r.faults[dafs_pkg::F_TERM]) begin
      s_nxt.term_num = term_hit;
    end

    // fault history logging, one code per cycle
    pick = lowest(s_r.faults & ~s_r.logged & dafs_pkg::LOG_MASK);
    log_code = fcode(pick[3:0], s_r.term_num);
    s_nxt.logged = clr_faults ? '0 : s_r.logged;
    if (pick[4]) begin
      s_nxt.logged[pick[3:0]] = 1'b1;
      // only fault codes reach the store
      if (s_r.hist_cnt < 3'(dafs_pkg::HIST_DEPTH) &&
          (s_r.hist_cnt == 3'h0 || log_code != s_r.hist_last)) begin
        mem_we = 1'b1;
        s_nxt.hist_cnt = s_r.hist_cnt + 3'h1;
        s_nxt.hist_last = log_code;
      end
    end

    // parameter checks
    perr_now = '0;
    perr_now[dafs_pkg::P_CAP] = s_r.misc[7:0] > dafs_pkg::CAP_MAX;
    for (int i = 0; i < 5; i++) begin
      if (mfsel(s_r.mfi, i) > dafs_pkg::MFI_SEL_MAX) begin
        perr_now[dafs_pkg::P_MFI] = 1'b1;
      end
      for (int j = i + 1; j < 5; j++) begin
        if (mfsel(s_r.mfi, i) != 5'h00 && mfsel(s_r.mfi, i) == mfsel(s_r.mfi, j)) begin
          perr_now[dafs_pkg::P_MFI] = 1'b1;
        end
      end
      if (s_r.misc[11:8] == dafs_pkg::AIM_MASTER &&
          mfsel(s_r.mfi, i) == dafs_pkg::MFI_MASTER_SEL) begin
        perr_now[dafs_pkg::P_CONS] = 1'b1;
      end
    end
    perr_now[dafs_pkg::P_VF] = !(s_r.vff[31:24] >= s_r.vff[23:16] &&
                                 s_r.vff[23:16] >= s_r.vff[15:8] &&
                                 s_r.vff[15:8] >= s_r.vff[7:0] &&
                                 s_r.vfv[23:16] >= s_r.vfv[15:8] &&
                                 s_r.vfv[15:8] >= s_r.vfv[7:0]);
    if (s_r.freq[15:0] > s_r.freq[31:16] || s_r.lim[15:0] < s_r.lim[31:16] ||
        (s_r.misc[11:8] == dafs_pkg::AIM_MASTER && s_r.misc[12])) begin
      perr_now[dafs_pkg::P_CONS] = 1'b1;
    end
    // evaluate in program mode, on its exit and at power-up
    eval = prog | (s_r.prog_prev & ~prog) | ~s_r.powered;
    s_nxt.powered = 1'b1;
    s_nxt.prog_prev = prog;
    if (eval) begin
      s_nxt.perr = perr_now;
    end

    // temporary write-failure display
    if (sense.nv_write_fail && prog) begin
      s_nxt.wf_show = 1'b1;
      s_nxt.wf_cnt = 13'h0000;
    end else if (s_r.wf_cnt == dafs_pkg::WRF_TICKS) begin
      s_nxt.wf_show = 1'b0;
      s_nxt.wf_cnt = 13'h0000;
    end else begin
      s_nxt.wf_cnt = tmr(s_r.wf_cnt, s_r.wf_show, tick, dafs_pkg::WRF_TICKS);
    end

    // blink phase from the common tick
    if (s_r.blink_cnt == dafs_pkg::BLINK_TICKS) begin
      s_nxt.blink_cnt = 13'h0000;
      s_nxt.blink_ph = ~s_r.blink_ph;
    end else begin
      s_nxt.blink_cnt = tmr(s_r.blink_cnt, 1'b1, tick, dafs_pkg::BLINK_TICKS);
    end

    // outputs
    s_nxt.ind.fault_active = |s_r.faults;
    s_nxt.ind.fault_relay = |s_r.faults;
    s_nxt.ind.fault_relay_terminals = (|s_r.faults) &
                                      (s_r.cfg[3:0] == dafs_pkg::RELAY_FN_FAULT);
    s_nxt.ind.alarm_active = |s_r.alarms;
    // alarms other than block and conflict leave output running
    s_nxt.ind.motor_enable = ~(|s_r.faults) & ~s_r.alarms[dafs_pkg::A_BLOCK] &
                             ~s_r.alarms[dafs_pkg::A_RC] &
                             (sense.run_fwd | sense.run_rev);
    fsel = lowest(s_r.faults);
    asel = lowest(s_r.alarms);
    psel = lowest({5'h00, s_r.perr});
    if (fsel[4]) begin
      // steady fault ahead of any alarm
      s_nxt.ind.disp_code = fcode(fsel[3:0], s_r.term_num);
      s_nxt.ind.disp_on = 1'b1;
    end else if (asel[4]) begin
      s_nxt.ind.disp_code = dafs_pkg::CODE_ALARM_BASE + {4'h0, asel[3:0]};
      s_nxt.ind.disp_on = s_r.blink_ph;
    end else if (psel[4]) begin
      s_nxt.ind.disp_code = dafs_pkg::CODE_PERR_BASE + {4'h0, psel[3:0]};
      s_nxt.ind.disp_on = 1'b1;
    end else if (s_r.wf_show) begin
      s_nxt.ind.disp_code = dafs_pkg::CODE_WRFAIL;
      s_nxt.ind.disp_on = 1'b1;
    end else begin
      s_nxt.ind.disp_code = dafs_pkg::CODE_NONE;
      s_nxt.ind.disp_on = 1'b0;
    end
  end

  // state register, synchronous reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
      s_r.opl <= dafs_pkg::OPL_WAIT;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign axi_rsp = s_r.rsp;
  assign ind = s_r.ind;
endmodule : dafs_supervisor
